// File: shared/srap_cfg.svh
// Purpose: timing counts, bit positions and fixed values of the register access port
// Assumes: sys_clk at 40 MHz
// Notes:   the base slave address is arbitrary; the strap pin fills its low bit
`ifndef SRAP_CFG_SVH
`define SRAP_CFG_SVH

`define SYS_CLK_MHZ      40
`define SYNC_RESET       6'h0F
`define SPI_RW_BIT       5'h00
`define SPI_ADDR_LAST    5'h07
`define SPI_DATA_FIRST   5'h10
`define SPI_DATA_LAST    5'h17
`define I2C_ACK_BIT      4'h8
`define I2C_ACK_END      4'h9
`define I2C_BASE_ADDR    6'h0C
`define STRETCH_MAX_NS   1000
`define STRETCH_CYC      6'((`STRETCH_MAX_NS * `SYS_CLK_MHZ) / 1000)
`define HOST_Q_NS        125
`define HOST_Q_CYC       6'((`HOST_Q_NS * `SYS_CLK_MHZ + 999) / 1000)
`define CS_HOLD_NS       240
`define CS_HOLD_Q        4'((`CS_HOLD_NS * `SYS_CLK_MHZ / 1000 + 4) / 5)
`define CS_GAP_NS        600
`define CS_GAP_Q         4'((`CS_GAP_NS * `SYS_CLK_MHZ / 1000 + 4) / 5)

`endif

// File: shared/srap_pkg.sv
// Purpose: types shared by both ends of the register access port
// Assumes: nothing
// Notes:   timing and positions live in srap_cfg.svh
package srap_pkg;
  typedef enum {DI_IDLE, DI_ADDR, DI_REG, DI_WDATA, DI_RDATA, DI_SKIP} dev_i2c_state_t;
  typedef enum {H_IDLE, H_START, H_TX, H_RX, H_FETCH, H_STOP, H_SPI, H_GAP} host_state_t;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } wr_entry_t;
endpackage : srap_pkg

// File: shared/serial_link_if.sv
// Purpose: pins between host and device, SPI and I2C
// Assumes: pull-ups on the open-drain and idle lines
// Notes:   open-drain drivers only pull low, so each carries an enable only
`timescale 1ns/10ps
interface serial_link_if;
  logic spiSclk;
  logic spiCsN;
  logic hostMosiOut;
  logic hostMosiOe;
  logic devMosiOut;
  logic devMosiOe;
  logic devMisoOut;
  logic devMisoOe;
  logic hostSclOe;
  logic hostSdaOe;
  logic devSclOe;
  logic devSdaOe;
  logic spiMosi;
  logic spiMiso;
  logic i2cScl;
  logic i2cSda;

  // resolved line levels
  assign spiMosi = devMosiOe ? devMosiOut : (hostMosiOe ? hostMosiOut : 1'b1);
  assign spiMiso = devMisoOe ? devMisoOut : 1'b1;
  assign i2cScl  = ~(hostSclOe | devSclOe);
  assign i2cSda  = ~(hostSdaOe | devSdaOe);

  modport dev (input spiSclk, spiCsN, spiMosi, i2cScl, i2cSda,
               output devMosiOut, devMosiOe, devMisoOut, devMisoOe, devSclOe, devSdaOe);
  modport host (output spiSclk, spiCsN, hostMosiOut, hostMosiOe, hostSclOe, hostSdaOe,
                input spiMosi, spiMiso, i2cScl, i2cSda);
endinterface : serial_link_if

// File: rtl/srap_device.sv
// Purpose: device end, byte register access over I2C or SPI mode 0
// Assumes: regRdData answers regRdAddr combinationally on sys_clk
// Notes:   writes leave through a two-entry buffer; I2C stretches SCL when it is full
// Operation
// - I2C read: address, register, restart, read
// - master NAKs last byte then stops
// - burst read advances pointer while acknowledged
// - NAK plus stop ends read, release SDA
// - I2C write: address, register, data, stop
// - write byte lands in addressed register
// - pointer advances after each written byte
// - SPI slave only, host frames transfers
// - mode 0: sample rising, shift falling
// - chip select low for whole transfer
// - 24 clocks per byte, 8 more each
// - first clock is direction, 1 read
// - next seven clocks give register address
// - second byte ignored, data on 17-24
// - 4-wire default, 3-wire when bit set
// - SPI write address increments every byte
// - 4-wire read drives MISO on 17-24
// - SPI read address increments every byte
// - 3-wire turns around at fall 16
// - 3-wire keeps MISO driver off
// - I2C answers only its own address
// - read stretch at most 1 us after ack
`timescale 1ns/10ps
`include "srap_cfg.svh"
module srap_device
  import srap_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // link pins
  serial_link_if.dev      link,
  // configuration
  input  wire logic       addressSelectPin,
  input  wire logic       spiThreeWire,
  // register read port
  output logic [6:0]      regRdAddr,
  input  wire logic [7:0] regRdData,
  // register write stream
  output logic            wrValid,
  input  wire logic       wrReady,
  output wr_entry_t       wrEntry
);

  logic [5:0]     syncA;
  logic [5:0]     syncB;
  logic [5:0]     prevB;
  logic [6:0]     myAddr;
  logic           sclkRise;
  logic           sclkFall;
  logic           csHigh;
  logic           mosiIn;
  logic           sclIn;
  logic           sdaIn;
  logic           sclRise;
  logic           sclFall;
  logic           i2cStart;
  logic           i2cStop;
  logic [4:0]     spiCnt;
  logic           spiRd;
  logic [6:0]     spiSr;
  logic [6:0]     spiPtr;
  logic [7:0]     spiTx;
  logic           spiDrive;
  logic           spiPush;
  dev_i2c_state_t iSt;
  logic [3:0]     iCnt;
  logic [7:0]     iSr;
  logic [7:0]     iTx;
  logic [6:0]     iPtr;
  logic           iAckM;
  logic [5:0]     stretch;
  logic           wStall;
  logic           i2cPush;
  wr_entry_t      i2cEntry;
  logic           inValid;
  logic           inReady;
  wr_entry_t      inEntry;
  logic           spValid;
  wr_entry_t      spEntry;
  logic           pop;

  // two-stage synchronisers for every pin, strap included
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      syncA <= `SYNC_RESET;
      syncB <= `SYNC_RESET;
      prevB <= `SYNC_RESET;
    end else begin
      syncA <= {addressSelectPin, link.spiSclk, link.spiCsN, link.spiMosi, link.i2cScl,
                link.i2cSda};
      syncB <= syncA;
      prevB <= syncB;
    end
  end

  // edges and conditions seen on the synchronised pins
  assign sclkRise = syncB[4] & ~prevB[4];
  assign sclkFall = ~syncB[4] & prevB[4];
  assign csHigh   = syncB[3];
  assign mosiIn   = syncB[2];
  assign sclIn    = syncB[1];
  assign sdaIn    = syncB[0];
  assign sclRise  = sclIn & ~prevB[1];
  assign sclFall  = ~sclIn & prevB[1];
  assign i2cStart = sclIn & prevB[1] & ~sdaIn & prevB[0];
  assign i2cStop  = sclIn & prevB[1] & sdaIn & ~prevB[0];

  // own slave address, low bit from the strap
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      myAddr <= {`I2C_BASE_ADDR, 1'b0};
    end else begin
      myAddr <= {`I2C_BASE_ADDR, syncB[5]};
    end
  end

  // spi bit counter, direction, address and read shifter
  always_ff @(posedge sys_clk) begin
    if (srst || csHigh) begin
      spiCnt   <= 5'h00;
      spiDrive <= 1'b0;
      spiRd    <= 1'b0;
      spiSr    <= 7'h00;
      spiPtr   <= 7'h00;
      spiTx    <= 8'h00;
    end else if (sclkRise) begin
      spiSr <= {spiSr[5:0], mosiIn};
      if (spiCnt == `SPI_RW_BIT) begin
        spiRd <= mosiIn;
      end
      if (spiCnt == `SPI_ADDR_LAST) begin
        spiPtr <= {spiSr[5:0], mosiIn};
      end
      if (spiCnt == `SPI_DATA_LAST) begin
        spiPtr <= spiPtr + 7'h01;
        spiCnt <= `SPI_DATA_FIRST;
      end else begin
        spiCnt <= spiCnt + 5'h01;
      end
    end else if (sclkFall && spiRd && spiCnt >= `SPI_DATA_FIRST) begin
      spiDrive <= 1'b1;
      spiTx    <= (spiCnt == `SPI_DATA_FIRST) ? regRdData : {spiTx[6:0], 1'b0};
    end
  end

  // spi write byte complete on the 24th rising edge of the frame, then on every 8th one after
  assign spiPush = sclkRise & ~csHigh & ~spiRd & (spiCnt == `SPI_DATA_LAST);

  // spi output pins, mode chosen by the wire-mode bit
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      link.devMisoOe  <= 1'b0;
      link.devMisoOut <= 1'b0;
      link.devMosiOe  <= 1'b0;
      link.devMosiOut <= 1'b0;
    end else begin
      link.devMisoOe  <= spiDrive & ~spiThreeWire & ~csHigh;
      link.devMisoOut <= spiTx[7];
      link.devMosiOe  <= spiDrive & spiThreeWire & ~csHigh;
      link.devMosiOut <= spiTx[7];
    end
  end

  // i2c slave: address match, pointer, write and read bytes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      iSt           <= DI_IDLE;
      iCnt          <= 4'h0;
      iSr           <= 8'h00;
      iTx           <= 8'h00;
      iPtr          <= 7'h00;
      iAckM         <= 1'b0;
      stretch       <= 6'h00;
      wStall        <= 1'b0;
      i2cPush       <= 1'b0;
      i2cEntry      <= '0;
      link.devSdaOe <= 1'b0;
      link.devSclOe <= 1'b0;
    end else begin
      i2cPush <= 1'b0;
      if (i2cStart) begin
        iSt           <= DI_ADDR;
        iCnt          <= 4'h0;
        stretch       <= 6'h00;
        wStall        <= 1'b0;
        link.devSdaOe <= 1'b0;
        link.devSclOe <= 1'b0;
      end else if (i2cStop) begin
        iSt           <= DI_IDLE;
        stretch       <= 6'h00;
        wStall        <= 1'b0;
        link.devSdaOe <= 1'b0;
        link.devSclOe <= 1'b0;
      end else if (wStall) begin
        if (link.devSdaOe) begin
          wStall        <= 1'b0;  // ack already on sda, now let scl go
          link.devSclOe <= 1'b0;
        end else if (inReady) begin
          i2cPush       <= 1'b1;
          i2cEntry      <= '{addr: iPtr, data: iSr};
          iPtr          <= iPtr + 7'h01;
          link.devSdaOe <= 1'b1;
        end
      end else if (stretch != 6'h00) begin
        stretch <= stretch - 6'h01;
        if (stretch == 6'h02) begin
          iTx           <= regRdData;
          link.devSdaOe <= ~regRdData[7];
        end
        link.devSclOe <= (stretch != 6'h01);  // sda settles before scl is let go
      end else if (iSt != DI_IDLE && iSt != DI_SKIP) begin
        if (sclRise) begin
          if (iCnt < `I2C_ACK_BIT) begin
            iSr <= {iSr[6:0], sdaIn};
          end
          if (iSt == DI_RDATA && iCnt == `I2C_ACK_BIT) begin
            iAckM <= ~sdaIn;
            if (~sdaIn) begin
              iPtr <= iPtr + 7'h01;
            end
          end
          iCnt <= iCnt + 4'h1;
        end else if (sclFall) begin
          if (iCnt == `I2C_ACK_BIT) begin
            unique case (iSt)
              DI_ADDR: begin
                if (iSr[7:1] == myAddr) begin
                  link.devSdaOe <= 1'b1;
                end else begin
                  iSt <= DI_SKIP;
                end
              end
              DI_REG: begin
                iPtr          <= iSr[6:0];
                link.devSdaOe <= 1'b1;
              end
              DI_WDATA: begin
                if (inReady) begin
                  i2cPush       <= 1'b1;
                  i2cEntry      <= '{addr: iPtr, data: iSr};
                  iPtr          <= iPtr + 7'h01;
                  link.devSdaOe <= 1'b1;
                end else begin
                  wStall        <= 1'b1;
                  link.devSclOe <= 1'b1;
                end
              end
              DI_RDATA: link.devSdaOe <= 1'b0;
              default: ;
            endcase
          end else if (iCnt == `I2C_ACK_END) begin
            iCnt          <= 4'h0;
            link.devSdaOe <= 1'b0;
            unique case (iSt)
              DI_ADDR: begin
                if (iSr[0]) begin
                  iSt           <= DI_RDATA;
                  iTx           <= regRdData;  // no stretch before a master ack
                  link.devSdaOe <= ~regRdData[7];
                end else begin
                  iSt <= DI_REG;
                end
              end
              DI_REG: iSt <= DI_WDATA;
              DI_RDATA: begin
                if (iAckM) begin
                  stretch       <= `STRETCH_CYC;
                  link.devSclOe <= 1'b1;
                end else begin
                  iSt <= DI_SKIP;
                end
              end
              default: ;
            endcase
          end else if (iSt == DI_RDATA) begin
            iTx           <= {iTx[6:0], 1'b0};
            link.devSdaOe <= ~iTx[6];
          end
        end
      end
    end
  end

  // read address follows whichever link is framed
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      regRdAddr <= 7'h00;
    end else begin
      regRdAddr <= csHigh ? iPtr : spiPtr;
    end
  end

  // write buffer: head register plus one spare entry
  assign inValid = spiPush | i2cPush;
  assign inEntry = i2cPush ? i2cEntry : wr_entry_t'{addr: spiPtr, data: {spiSr, mosiIn}};
  assign inReady = ~spValid;
  assign pop     = wrValid & wrReady;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wrValid <= 1'b0;
      wrEntry <= '0;
      spValid <= 1'b0;
      spEntry <= '0;
    end else begin
      wrValid <= spValid | (inValid & inReady) | (wrValid & ~pop);
      if (~wrValid || pop) begin
        if (spValid) begin
          wrEntry <= spEntry;
        end else if (inValid) begin
          wrEntry <= inEntry;
        end
      end
      if (inValid && inReady && wrValid && ~pop) begin
        spValid <= 1'b1;
        spEntry <= inEntry;
      end else if (pop) begin
        spValid <= 1'b0;
      end
    end
  end

endmodule : srap_device

// File: rtl/srap_host.sv
// Purpose: host end, issues register reads and writes over SPI or I2C
// Assumes: one command at a time; cmdLen of at least one byte
// Notes:   SPI clock and I2C SCL come from a divider of sys_clk
`timescale 1ns/10ps
`include "srap_cfg.svh"
module srap_host
  import srap_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // link pins
  serial_link_if.host     link,
  // command
  input  wire logic       cmdValid,
  output logic            cmdReady,
  input  wire logic       cmdI2c,
  input  wire logic       cmdRead,
  input  wire logic [6:0] cmdReg,
  input  wire logic [3:0] cmdLen,
  input  wire logic [6:0] devAddr,
  input  wire logic       threeWire,
  // write bytes
  input  wire logic       wrValid,
  output logic            wrReady,
  input  wire logic [7:0] wrData,
  // read bytes
  output logic            rdValid,
  output logic [7:0]      rdData
);

  logic [3:0]  syncA;
  logic [3:0]  syncB;
  host_state_t st;
  logic [5:0]  tick;
  logic [1:0]  q;
  logic        adv;
  logic [3:0]  bitN;
  logic [3:0]  left;
  logic [1:0]  phase;
  logic [7:0]  tx;
  logic [7:0]  rx;
  logic        rd;
  logic        i2c;
  logic [6:0]  regA;
  logic        spiIn;

  // synchronisers for returned lines
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      syncA <= 4'hF;
      syncB <= 4'hF;
    end else begin
      syncA <= {link.spiMiso, link.spiMosi, link.i2cScl, link.i2cSda};
      syncB <= syncA;
    end
  end

  // quarter-bit pacing, held while the slave stretches SCL
  assign adv   = (tick == `HOST_Q_CYC - 6'h01) && ~(i2c && q == 2'h2 && ~syncB[1]);
  assign spiIn = threeWire ? syncB[2] : syncB[3];

  always_ff @(posedge sys_clk) begin
    if (srst || st == H_IDLE || st == H_FETCH || tick == `HOST_Q_CYC - 6'h01) begin
      tick <= 6'h00;
    end else begin
      tick <= tick + 6'h01;
    end
  end

  // transfer sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st               <= H_IDLE;
      q                <= 2'h0;
      bitN             <= 4'h0;
      left             <= 4'h0;
      phase            <= 2'h0;
      tx               <= 8'h00;
      rx               <= 8'h00;
      rd               <= 1'b0;
      i2c              <= 1'b0;
      regA             <= 7'h00;
      cmdReady         <= 1'b1;
      wrReady          <= 1'b0;
      rdValid          <= 1'b0;
      rdData           <= 8'h00;
      link.spiSclk     <= 1'b0;
      link.spiCsN      <= 1'b1;
      link.hostMosiOut <= 1'b0;
      link.hostMosiOe  <= 1'b0;
      link.hostSclOe   <= 1'b0;
      link.hostSdaOe   <= 1'b0;
    end else begin
      rdValid <= 1'b0;
      if (st == H_IDLE) begin
        if (cmdValid && cmdReady) begin
          cmdReady    <= 1'b0;
          rd          <= cmdRead;
          i2c         <= cmdI2c;
          regA        <= cmdReg;
          left        <= cmdLen;
          phase       <= 2'h0;
          bitN        <= 4'h0;
          q           <= 2'h0;
          st          <= cmdI2c ? H_START : H_SPI;
          tx          <= cmdI2c ? {devAddr, 1'b0} : {cmdRead, cmdReg};
          link.spiCsN <= cmdI2c;
        end
      end else if (st == H_FETCH) begin
        wrReady <= 1'b1;
        if (wrValid && wrReady) begin
          wrReady <= 1'b0;
          tx      <= wrData;
          q       <= 2'h0;
          st      <= i2c ? H_TX : H_SPI;
        end
      end else if (adv) begin
        q <= q + 2'h1;
        unique case (st)
          H_START: begin
            unique case (q)
              2'h0: link.hostSdaOe <= 1'b0;
              2'h1: link.hostSclOe <= 1'b0;
              2'h2: link.hostSdaOe <= 1'b1;
              2'h3: begin
                link.hostSclOe <= 1'b1;
                st             <= H_TX;
                bitN           <= 4'h0;
              end
            endcase
          end
          H_TX: begin
            unique case (q)
              2'h0: link.hostSdaOe <= (bitN < `I2C_ACK_BIT) & ~tx[7];
              2'h1: link.hostSclOe <= 1'b0;
              2'h2: ;
              2'h3: begin
                link.hostSclOe <= 1'b1;
                if (bitN < `I2C_ACK_BIT) begin
                  tx   <= {tx[6:0], 1'b0};
                  bitN <= bitN + 4'h1;
                end else begin
                  bitN <= 4'h0;
                  if (syncB[0]) begin
                    st <= H_STOP;
                  end else if (phase == 2'h0) begin
                    tx    <= {1'b0, regA};
                    phase <= 2'h1;
                  end else if (phase == 2'h1) begin
                    phase <= 2'h2;
                    tx    <= {devAddr, 1'b1};
                    st    <= rd ? H_START : H_FETCH;
                  end else if (rd) begin
                    st <= H_RX;
                  end else begin
                    left <= left - 4'h1;
                    st   <= (left == 4'h1) ? H_STOP : H_FETCH;
                  end
                end
              end
            endcase
          end
          H_RX: begin
            unique case (q)
              2'h0: link.hostSdaOe <= (bitN == `I2C_ACK_BIT) & (left != 4'h1);
              2'h1: link.hostSclOe <= 1'b0;
              2'h2: begin
                if (bitN < `I2C_ACK_BIT) begin
                  rx <= {rx[6:0], syncB[0]};
                end
              end
              2'h3: begin
                link.hostSclOe <= 1'b1;
                if (bitN < `I2C_ACK_BIT) begin
                  bitN <= bitN + 4'h1;
                end else begin
                  bitN    <= 4'h0;
                  rdValid <= 1'b1;
                  rdData  <= rx;
                  left    <= left - 4'h1;
                  if (left == 4'h1) begin
                    st <= H_STOP;
                  end
                end
              end
            endcase
          end
          H_STOP: begin
            unique case (q)
              2'h0: link.hostSdaOe <= 1'b1;
              2'h1: link.hostSclOe <= 1'b0;
              2'h2: link.hostSdaOe <= 1'b0;
              2'h3: begin
                st   <= H_GAP;
                bitN <= 4'h0;
              end
            endcase
          end
          H_SPI: begin
            unique case (q)
              2'h0: begin
                link.hostMosiOut <= tx[7];
                link.hostMosiOe  <= ~(threeWire & rd & phase == 2'h2);
              end
              2'h1: link.spiSclk <= 1'b1;
              2'h2: ;
              2'h3: begin
                link.spiSclk <= 1'b0;
                rx           <= {rx[6:0], spiIn};
                tx           <= {tx[6:0], 1'b0};
                bitN         <= bitN + 4'h1;
                if (bitN == 4'h7) begin
                  bitN <= 4'h0;
                  if (phase == 2'h0) begin
                    phase <= 2'h1;
                    tx    <= 8'h00;
                  end else if (phase == 2'h1) begin
                    phase           <= 2'h2;
                    link.hostMosiOe <= ~(threeWire & rd);
                    st              <= rd ? H_SPI : H_FETCH;
                  end else begin
                    left <= left - 4'h1;
                    if (rd) begin
                      rdValid <= 1'b1;
                      rdData  <= {rx[6:0], spiIn};
                    end
                    if (left == 4'h1) begin
                      st <= H_GAP;
                    end else if (~rd) begin
                      st <= H_FETCH;
                    end
                  end
                end
              end
            endcase
          end
          H_GAP: begin
            bitN <= bitN + 4'h1;
            if (bitN == `CS_HOLD_Q) begin
              link.spiCsN     <= 1'b1;
              link.hostMosiOe <= 1'b0;
            end
            if (bitN == `CS_HOLD_Q + `CS_GAP_Q) begin
              st       <= H_IDLE;
              cmdReady <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

endmodule : srap_host

// File: rtl/placeholder_none.sv
`timescale 1ns/10ps

// File: bench/srap_link_monitor.sv
// Purpose: watches the pins between host and device
// Assumes: sys_clk samples every pin
// Notes:   riseCnt counts rising sclk edges under chip select
`timescale 1ns/10ps
module srap_link_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // spi pins
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic hostMosiOut,
  input wire logic hostMosiOe,
  input wire logic devMosiOe,
  input wire logic devMisoOut,
  input wire logic devMisoOe,
  // i2c pins
  input wire logic i2cScl,
  input wire logic devSdaOe
);
  logic [7:0] riseCnt;
  logic       sclkQ;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // rising sclk edges in the current frame
  always_ff @(posedge sys_clk) begin
    sclkQ <= spiSclk;
    if (srst || spiCsN) riseCnt <= 8'h00;
    else if (spiSclk && !sclkQ) riseCnt <= riseCnt + 8'h01;
  end
  a_sclk_idle_low: assert property (spiCsN |-> !spiSclk)
    else $error("sclk high outside a frame");
  a_frame_length: assert property ($rose(spiCsN) |-> riseCnt >= 8'h18 && riseCnt[2:0] == 3'h0)
    else $error("frame is not 24 plus whole bytes of clocks");
  a_drive_after_16: assert property ($rose(devMisoOe) || $rose(devMosiOe) |->
    !spiCsN && !spiSclk && riseCnt >= 8'h10)
    else $error("device drives before fall of clock 16");
  a_release_idle: assert property (spiCsN [*8] |-> !devMisoOe && !devMosiOe)
    else $error("device drive left on after chip select");
  a_no_contention: assert property (!(devMosiOe && hostMosiOe))
    else $error("both ends drive the data pin");
  a_miso_hold: assert property (devMisoOe && spiSclk && $past(spiSclk) |-> $stable(devMisoOut))
    else $error("device data moved while sclk high");
  a_mosi_hold: assert property (hostMosiOe && spiSclk && $past(spiSclk) |-> $stable(hostMosiOut))
    else $error("host data moved while sclk high");
  a_sda_scl_low: assert property ($changed(devSdaOe) |-> !i2cScl)
    else $error("device moved sda while scl high");
endmodule : srap_link_monitor

// File: bench/serial_register_access_port_test.sv
// Purpose: both ends joined over the link, random register traffic
// Assumes: the bench holds the register array behind the device
// Notes:   entries and read bytes are compared with bench copies
`timescale 1ns/10ps
module serial_register_access_port_test;
  import srap_pkg::*;
  logic       sys_clk = 1'h0;
  logic       srst = 1'h1;
  logic       cmdValid = 1'h0, cmdI2c = 1'h0, cmdRead = 1'h0, threeWire = 1'h0, pin = 1'h0;
  logic [6:0] cmdReg = 7'h00, devAddr = 7'h00, regRdAddr;
  logic [3:0] cmdLen = 4'h1, wIdx = 4'h0;
  logic       cmdReady, hWrReady, rdValid, dWrValid, dWrReady = 1'h1;
  logic [7:0] rdData, mem [128], shadow [128], wb [16];
  wr_entry_t  wrEntry;
  wr_entry_t  wq [$];
  int         fail_count = 0, cmp_count = 0, nRd = 0, rPtr = 0;
  serial_link_if link ();
  srap_host u_srap_host (.sys_clk(sys_clk), .srst(srst), .link(link.host),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdI2c(cmdI2c), .cmdRead(cmdRead),
    .cmdReg(cmdReg), .cmdLen(cmdLen), .devAddr(devAddr), .threeWire(threeWire),
    .wrValid(1'h1), .wrReady(hWrReady), .wrData(wb[wIdx]), .rdValid(rdValid), .rdData(rdData));
  srap_device u_srap_device (.sys_clk(sys_clk), .srst(srst), .link(link.dev),
    .addressSelectPin(pin), .spiThreeWire(threeWire), .regRdAddr(regRdAddr),
    .regRdData(mem[regRdAddr]), .wrValid(dWrValid), .wrReady(dWrReady), .wrEntry(wrEntry));
  srap_link_monitor u_srap_link_monitor (.sys_clk(sys_clk), .srst(srst),
    .spiSclk(link.spiSclk), .spiCsN(link.spiCsN), .hostMosiOut(link.hostMosiOut),
    .hostMosiOe(link.hostMosiOe), .devMosiOe(link.devMosiOe), .devMisoOut(link.devMisoOut),
    .devMisoOe(link.devMisoOe), .i2cScl(link.i2cScl), .devSdaOe(link.devSdaOe));
  always #12.5 sys_clk = ~sys_clk;
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out();
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // register array, stalling write stream and byte checks
  always @(posedge sys_clk) begin
    dWrReady <= ($urandom % 4) != 0;
    if (hWrReady) wIdx <= wIdx + 4'h1;
    if (rdValid) begin
      chk("rdData", 16'(shadow[rPtr]), 16'(rdData));
      rPtr++;
      nRd++;
    end
    if (dWrValid && dWrReady) begin
      mem[wrEntry.addr] <= wrEntry.data;
      if (wq.size() == 0) chk("strayEntry", 16'h0000, 16'(wrEntry));
      else chk("wrEntry", 16'(wq.pop_front()), 16'(wrEntry));
    end
    if (threeWire) chk("misoOe", 16'h0000, 16'(link.devMisoOe));
  end
  // one command through the host, good selects the right slave address
  task automatic run(bit i2c, bit rd, bit tw, logic [6:0] rg, logic [3:0] ln, bit good);
    logic [7:0] d;
    int         n;
    @(posedge sys_clk);
    for (int k = 0; k < ln; k++) begin
      d = 8'($urandom);
      wb[wIdx + 4'(k)] = d;
      if (!rd && good) begin
        shadow[rg + 7'(k)] = d;
        wq.push_back({7'(rg + 7'(k)), d});
      end
    end
    rPtr = rg;
    nRd = 0;
    cmdValid <= 1'h1;
    cmdI2c <= i2c;
    cmdRead <= rd;
    threeWire <= tw && !i2c;
    cmdReg <= rg;
    cmdLen <= ln;
    devAddr <= {6'h0C, pin ^ !good};
    @(posedge sys_clk);
    cmdValid <= 1'h0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((cmdReady !== 1'h1 || wq.size() != 0) && n < 20000);
    chk("cmdDone", 16'h0001, 16'(cmdReady));
    chk("rdCount", (rd && good) ? 16'(ln) : 16'h0000, 16'(nRd));
    chk("wrLeft", 16'h0000, 16'(wq.size()));
  endtask : run
  // watchdog
  initial begin
    #2500000;
    fail_count++;
    close_out();
  end
  initial begin
    void'($urandom(18979));
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'($urandom);
      shadow[i] = mem[i];
    end
    pin <= 1'($urandom);
    repeat (4) @(posedge sys_clk);
    srst <= 1'h0;
    repeat (3) @(posedge sys_clk);
    run(1'h0, 1'h0, 1'h0, 7'h00, 4'hF, 1'h1);
    run(1'h0, 1'h1, 1'h0, 7'h00, 4'hF, 1'h1);
    run(1'h0, 1'h1, 1'h1, 7'h7F, 4'h1, 1'h1);
    run(1'h1, 1'h0, 1'h0, 7'h10, 4'h3, 1'h1);
    run(1'h1, 1'h1, 1'h0, 7'h10, 4'h3, 1'h1);
    run(1'h1, 1'h0, 1'h0, 7'h20, 4'h1, 1'h0);
    run(1'h1, 1'h1, 1'h0, 7'h7F, 4'h1, 1'h1);
    for (int i = 0; i < 16; i++) begin
      run(1'($urandom), 1'($urandom), 1'($urandom), 7'($urandom % 124),
          4'(1 + $urandom % 4), 1'h1);
    end
    close_out();
  end
endmodule : serial_register_access_port_test
